/* core/acr_map.svh */
// Register offsets, field positions, reset values and timing counts of the converter block.
// Assumes a 32-bit APB slave with byte addresses on a 12-bit bus; every register is one word.
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// Register byte offsets
`define ACR_OFS_PRST 12'h000
`define ACR_OFS_CLKEN 12'h004
`define ACR_OFS_MODE0 12'h008
`define ACR_OFS_TRIG 12'h00c
`define ACR_OFS_MODE2 12'h010
`define ACR_OFS_ULIM 12'h014
`define ACR_OFS_LLIM 12'h018
`define ACR_OFS_CHAN 12'h01c
`define ACR_OFS_MASK 12'h020
`define ACR_OFS_IFLAG 12'h024
`define ACR_OFS_PRIO1 12'h028
`define ACR_OFS_PRIO0 12'h02c
`define ACR_OFS_P2SEL 12'h030
`define ACR_OFS_P2DIR 12'h034
`define ACR_OFS_RESULT 12'h038
`define ACR_OFS_STAT 12'h03c
`define ACR_OFS_CLR 12'h040
`define ACR_OFS_ENA 12'h044

// Field positions
`define ACR_CONV_RESET_BIT 5
`define ACR_CONV_GATE_BIT 5
`define ACR_RUN_BIT 7
`define ACR_SCAN_BIT 6
`define ACR_CMP_BIT 0
`define ACR_ONESHOT_BIT 5
`define ACR_INVERT_BIT 3
`define ACR_RES8_BIT 0

// Reset values
`define ACR_RST_MASK 8'h01
`define ACR_RST_PRIO 8'h01
`define ACR_RST_PORT 8'hff
`define ACR_PORT_FIXED 8'hf0
`define ACR_RST_ULIM 8'hff

// Timing: power stabilisation wait, rounded up to whole clocks
`define ACR_CLK_MHZ 100
`define ACR_STAB_NS 1000
`define ACR_STAB_CYC ((`ACR_STAB_NS * `ACR_CLK_MHZ + 999) / 1000)
`define ACR_SCAN_LAST 2'h3

`endif

/* core/acr_pkg.sv */
// Types of the converter control block: sequencer states, core carriers and the state record.
// Assumes acr_map.svh supplies all numbers.
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'h0,
    ACR_STAB = 2'h1,
    ACR_CONV = 2'h3,
    ACR_NEXT = 2'h2
  } acr_seq_t;

  // Requests from the control block to the analog core
  typedef struct packed {
    logic reset_hold;
    logic clock_gate;
    logic comparator_en;
    logic start;
    logic [4:0] channel;
    logic clk_tick;
    logic [1:0] speed;
    logic res8;
  } acr_core_req_t;

  // Answer of the analog core
  typedef struct packed {
    logic valid;
    logic [9:0] data;
  } acr_core_rsp_t;

  typedef struct packed {
    logic [7:0] prst, clken, mode0, trig, mode2, ulim, llim, chan;
    logic [7:0] mask, iflag, pr1, pr0, pmc, pm;
    logic [15:0] result;
    logic [2:0] status, enable;
    acr_seq_t seq;
    logic [1:0] idx;
    logic [15:0] cnt;
    logic [5:0] div_cnt;
    logic div_tick, start;
    logic trig_meta, trig_sync, trig_prev;
    logic [31:0] rdata;
    logic slverr;
  } acr_state_t;

endpackage

/* core/acr_ctrl.sv */
// Control and status logic around a successive-approximation converter, APB register slave.
// Assumes the analog core shares ref_clk; the hardware trigger pin is asynchronous.
//
// Behaviour
// - Converter reset bit at 1 holds the converter logic in reset.
// - Clock gate bit at 0 stops converter clock; converter registers ignore writes.
// - Writing run bit 1 enables conversion, 0 stops it; 0 reads as stopped.
// - Run bit 1 means converting, or stabilisation wait plus conversion in wait mode.
// - Comparator power bit turns the voltage comparator on or off.
// - Conversion-end mask bit at 1 blocks servicing of the interrupt.
// - Pending flag set on conversion end when the window check fires; software writes 0 to clear it.
// - Two priority bits encode level 0 (highest) to level 3 (lowest).
// - Port 2 low bits select analog input; upper four bits fixed at 1.
// - Port 2 direction bit 1 turns the output buffer off, 0 turns it on.
// - Scan bit 0 converts one channel, 1 converts a group of channels in turn.
// - Clock-select bits set divisor 64 down to 2; speed bits pick Normal 1 or 2.
// - Trigger field: upper bit 0 software, 10 hardware no-wait, 11 hardware wait.
// - Interrupt raised inside limit window, or outside it when invert bit is 1.
// - Resolution bit 0 selects 10-bit, 1 selects 8-bit conversion.
`timescale 1ns/10ps
`include "acr_map.svh"

module acr_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog core
  output acr_pkg::acr_core_req_t core_req,
  input wire acr_pkg::acr_core_rsp_t core_rsp,
  input wire logic hw_trigger,
  // Port 2 pins
  output logic [3:0] port2_analog_sel,
  output logic [3:0] port2_out_en,
  // Interrupts
  output logic conv_end_irq_req,
  output logic [1:0] conv_end_prio,
  output logic irq
);
  import acr_pkg::*;

  acr_state_t s_reg, s_next;
  logic setup, wr_acc, conv_reg_wr, clocked, trig_edge, fire, seq_done;
  logic [4:0] wr_sel;
  logic [7:0] r8;

  // Address decode, used for reads in setup and for writes in access
  function automatic logic [4:0] reg_sel(input logic [11:0] a);
    case (a)
      `ACR_OFS_PRST: reg_sel = 5'h00;
      `ACR_OFS_CLKEN: reg_sel = 5'h01;
      `ACR_OFS_MODE0: reg_sel = 5'h02;
      `ACR_OFS_TRIG: reg_sel = 5'h03;
      `ACR_OFS_MODE2: reg_sel = 5'h04;
      `ACR_OFS_ULIM: reg_sel = 5'h05;
      `ACR_OFS_LLIM: reg_sel = 5'h06;
      `ACR_OFS_CHAN: reg_sel = 5'h07;
      `ACR_OFS_MASK: reg_sel = 5'h08;
      `ACR_OFS_IFLAG: reg_sel = 5'h09;
      `ACR_OFS_PRIO1: reg_sel = 5'h0a;
      `ACR_OFS_PRIO0: reg_sel = 5'h0b;
      `ACR_OFS_P2SEL: reg_sel = 5'h0c;
      `ACR_OFS_P2DIR: reg_sel = 5'h0d;
      `ACR_OFS_RESULT: reg_sel = 5'h0e;
      `ACR_OFS_STAT: reg_sel = 5'h0f;
      `ACR_OFS_CLR: reg_sel = 5'h10;
      `ACR_OFS_ENA: reg_sel = 5'h11;
      default: reg_sel = 5'h1f;
    endcase
  endfunction

  // Divider terminal count per clock-select code
  function automatic logic [5:0] div_last(input logic [2:0] fr);
    case (fr)
      3'h0: div_last = 6'h3f;
      3'h1: div_last = 6'h1f;
      3'h2: div_last = 6'h0f;
      3'h3: div_last = 6'h07;
      3'h4: div_last = 6'h05;
      3'h5: div_last = 6'h04;
      3'h6: div_last = 6'h03;
      default: div_last = 6'h01;
    endcase
  endfunction

  // State after reset; also the converter part of it while the reset bit is held
  function automatic acr_state_t reset_state();
    acr_state_t r;
    r = '0;
    r.ulim = `ACR_RST_ULIM;
    r.mask = `ACR_RST_MASK;
    r.pr1 = `ACR_RST_PRIO;
    r.pr0 = `ACR_RST_PRIO;
    r.pmc = `ACR_RST_PORT;
    r.pm = `ACR_RST_PORT;
    r.seq = ACR_IDLE;
    reset_state = r;
  endfunction

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign wr_sel = reg_sel(paddr);
  // Converter registers only accept writes with the clock running and reset released
  assign conv_reg_wr = wr_acc && s_reg.clken[`ACR_CONV_GATE_BIT]
    && !s_reg.prst[`ACR_CONV_RESET_BIT];
  assign clocked = s_reg.clken[`ACR_CONV_GATE_BIT] && !s_reg.prst[`ACR_CONV_RESET_BIT];
  assign trig_edge = s_reg.trig_sync && !s_reg.trig_prev;
  assign r8 = core_rsp.data[9:2];
  // Window check on the upper eight result bits against the 8-bit limits
  assign fire = ((s_reg.llim <= r8) && (r8 <= s_reg.ulim))
    ^ s_reg.mode2[`ACR_INVERT_BIT];
  assign seq_done = !s_reg.mode0[`ACR_SCAN_BIT] || (s_reg.idx == `ACR_SCAN_LAST);

  // Next-state logic: bus, sequencer and event flags
  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.div_tick = 1'b0;
    s_next.trig_meta = hw_trigger;
    s_next.trig_sync = s_reg.trig_meta;
    s_next.trig_prev = s_reg.trig_sync;
    // Read data is captured in the setup phase so prdata leaves a flip-flop
    if (setup) begin
      s_next.slverr = (reg_sel(paddr) == 5'h1f);
      case (reg_sel(paddr))
        5'h00: s_next.rdata = {24'h0, s_reg.prst};
        5'h01: s_next.rdata = {24'h0, s_reg.clken};
        5'h02: s_next.rdata = {24'h0, s_reg.mode0};
        5'h03: s_next.rdata = {24'h0, s_reg.trig};
        5'h04: s_next.rdata = {24'h0, s_reg.mode2};
        5'h05: s_next.rdata = {24'h0, s_reg.ulim};
        5'h06: s_next.rdata = {24'h0, s_reg.llim};
        5'h07: s_next.rdata = {24'h0, s_reg.chan};
        5'h08: s_next.rdata = {24'h0, s_reg.mask};
        5'h09: s_next.rdata = {24'h0, s_reg.iflag};
        5'h0a: s_next.rdata = {24'h0, s_reg.pr1};
        5'h0b: s_next.rdata = {24'h0, s_reg.pr0};
        5'h0c: s_next.rdata = {24'h0, s_reg.pmc};
        5'h0d: s_next.rdata = {24'h0, s_reg.pm};
        5'h0e: s_next.rdata = {16'h0, s_reg.result};
        5'h0f: s_next.rdata = {29'h0, s_reg.status};
        5'h11: s_next.rdata = {29'h0, s_reg.enable};
        default: s_next.rdata = 32'h0;
      endcase
    end
    // Register writes take effect at the access edge
    if (wr_acc) begin
      case (wr_sel)
        5'h00: s_next.prst = pwdata[7:0];
        5'h01: s_next.clken = pwdata[7:0];
        5'h08: s_next.mask = pwdata[7:0];
        5'h09: s_next.iflag = pwdata[7:0];
        5'h0a: s_next.pr1 = pwdata[7:0];
        5'h0b: s_next.pr0 = pwdata[7:0];
        5'h0c: s_next.pmc = pwdata[7:0] | `ACR_PORT_FIXED;
        5'h0d: s_next.pm = pwdata[7:0] | `ACR_PORT_FIXED;
        5'h10: s_next.status = s_reg.status & ~pwdata[2:0];
        5'h11: s_next.enable = pwdata[2:0];
        default: s_next.rdata = s_next.rdata;
      endcase
    end
    if (conv_reg_wr) begin
      case (wr_sel)
        5'h02: s_next.mode0 = pwdata[7:0];
        5'h03: s_next.trig = pwdata[7:0];
        5'h04: s_next.mode2 = pwdata[7:0];
        5'h05: s_next.ulim = pwdata[7:0];
        5'h06: s_next.llim = pwdata[7:0];
        5'h07: s_next.chan = pwdata[7:0];
        default: s_next.rdata = s_next.rdata;
      endcase
    end
    // Sequencer; frozen while the converter clock is gated off
    if (clocked) begin
      if (!s_next.mode0[`ACR_RUN_BIT]) begin
        s_next.seq = ACR_IDLE;
        s_next.idx = 2'h0;
      end else begin
        case (s_reg.seq)
          ACR_IDLE: begin
            if (!s_reg.trig[7]) begin
              if (s_reg.mode0[`ACR_CMP_BIT]) begin
                s_next.seq = ACR_CONV;
                s_next.start = 1'b1;
              end
            end else if (trig_edge && s_reg.mode0[`ACR_CMP_BIT]) begin
              if (s_reg.trig[6]) begin
                s_next.seq = ACR_STAB;
                s_next.cnt = 16'(`ACR_STAB_CYC - 1);
              end else begin
                s_next.seq = ACR_CONV;
                s_next.start = 1'b1;
              end
            end
          end
          ACR_STAB: begin
            if (s_reg.cnt == 16'h0) begin
              s_next.seq = ACR_CONV;
              s_next.start = 1'b1;
            end else begin
              s_next.cnt = s_reg.cnt - 16'h1;
            end
          end
          ACR_CONV: begin
            // Conversion clock divider feeds the core while it converts
            if (s_reg.div_cnt == div_last(s_reg.mode0[5:3])) begin
              s_next.div_cnt = 6'h0;
              s_next.div_tick = 1'b1;
            end else begin
              s_next.div_cnt = s_reg.div_cnt + 6'h1;
            end
            if (core_rsp.valid) begin
              // Result is stored upper-justified; 8-bit mode drops the two low bits
              s_next.result = s_reg.mode2[`ACR_RES8_BIT] ? {r8, 8'h0}
                : {core_rsp.data, 6'h0};
              s_next.seq = ACR_NEXT;
              s_next.div_cnt = 6'h0;
            end
          end
          ACR_NEXT: begin
            if (!seq_done) begin
              s_next.idx = s_reg.idx + 2'h1;
              s_next.seq = ACR_CONV;
              s_next.start = 1'b1;
            end else begin
              s_next.idx = 2'h0;
              if (s_reg.trig[`ACR_ONESHOT_BIT]) begin
                s_next.mode0[`ACR_RUN_BIT] = 1'b0;
                s_next.seq = ACR_IDLE;
              end else if (!s_reg.trig[7]) begin
                s_next.seq = ACR_CONV;
                s_next.start = 1'b1;
              end else begin
                s_next.seq = ACR_IDLE;
              end
            end
          end
          default: s_next.seq = ACR_IDLE;
        endcase
      end
    end
    // Events are applied last so a set wins over a clear in the same cycle
    if (clocked && s_reg.seq == ACR_CONV && core_rsp.valid) begin
      s_next.status[1] = 1'b1;
      if (fire) begin
        s_next.iflag[0] = 1'b1;
        s_next.status[0] = 1'b1;
      end
    end
    if (clocked && s_reg.seq == ACR_NEXT && seq_done && s_reg.trig[`ACR_ONESHOT_BIT]) begin
      s_next.status[2] = 1'b1;
    end
    // Held converter reset returns every converter field to its reset value
    if (s_next.prst[`ACR_CONV_RESET_BIT]) begin
      s_next.mode0 = 8'h0;
      s_next.trig = 8'h0;
      s_next.mode2 = 8'h0;
      s_next.ulim = `ACR_RST_ULIM;
      s_next.llim = 8'h0;
      s_next.chan = 8'h0;
      s_next.result = 16'h0;
      s_next.seq = ACR_IDLE;
      s_next.idx = 2'h0;
      s_next.cnt = 16'h0;
      s_next.div_cnt = 6'h0;
      s_next.start = 1'b0;
      s_next.div_tick = 1'b0;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_reg <= reset_state();
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus answer: one access cycle, data and error from flip-flops
  assign pready = 1'b1;
  assign prdata = s_reg.rdata;
  assign pslverr = psel && penable && s_reg.slverr;

  // Core requests
  assign core_req.reset_hold = s_reg.prst[`ACR_CONV_RESET_BIT];
  assign core_req.clock_gate = s_reg.clken[`ACR_CONV_GATE_BIT];
  assign core_req.comparator_en = s_reg.mode0[`ACR_CMP_BIT];
  assign core_req.start = s_reg.start;
  assign core_req.channel = s_reg.chan[4:0] + {3'h0, s_reg.idx};
  assign core_req.clk_tick = s_reg.div_tick;
  assign core_req.speed = s_reg.mode0[2:1];
  assign core_req.res8 = s_reg.mode2[`ACR_RES8_BIT];

  // Port 2 pin controls, one per analog channel
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign port2_analog_sel[gi] = s_reg.pmc[gi];
      assign port2_out_en[gi] = !s_reg.pm[gi];
    end
  endgenerate

  // Interrupt outputs
  assign conv_end_irq_req = s_reg.iflag[0] && !s_reg.mask[0];
  assign conv_end_prio = {s_reg.pr1[0], s_reg.pr0[0]};
  assign irq = |(s_reg.status & s_reg.enable);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_oneshot_end;
    s_reg.seq == ACR_NEXT && seq_done && s_reg.trig[`ACR_ONESHOT_BIT] && clocked;
  endsequence

  property p_reset_hold;
    s_next.prst[`ACR_CONV_RESET_BIT] |=> s_reg.seq == ACR_IDLE && s_reg.mode0 == 8'h0;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("converter not held");

  property p_gate_write;
    wr_acc && wr_sel == 5'h02 && !s_reg.clken[`ACR_CONV_GATE_BIT]
      && !s_reg.prst[`ACR_CONV_RESET_BIT] |=> $stable(s_reg.mode0);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gated write taken");

  property p_run_stop;
    conv_reg_wr && wr_sel == 5'h02 && !pwdata[`ACR_RUN_BIT] |=> s_reg.seq == ACR_IDLE;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("run clear did not stop");

  property p_stab_end;
    s_reg.seq == ACR_STAB && s_reg.cnt == 16'h0 && clocked && s_next.mode0[`ACR_RUN_BIT]
      |=> s_reg.seq == ACR_CONV && core_req.start;
  endproperty
  a_stab_end: assert property (p_stab_end) else $error("wait did not convert");

  property p_cmp_off;
    s_reg.seq == ACR_IDLE && !s_reg.mode0[`ACR_CMP_BIT] |=> !core_req.start;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("start with comparator off");

  property p_mask;
    s_reg.mask[0] |-> !conv_end_irq_req;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request serviced");

  property p_flag_set;
    clocked && s_reg.seq == ACR_CONV && core_rsp.valid && fire
      && !s_next.prst[`ACR_CONV_RESET_BIT] |=> s_reg.iflag[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("window hit lost");

  property p_flag_clr;
    wr_acc && wr_sel == 5'h09 && !pwdata[0] && !(clocked && s_reg.seq == ACR_CONV
      && core_rsp.valid) |=> !s_reg.iflag[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("pending flag not cleared");

  property p_port_fixed;
    s_reg.pmc[7:4] == 4'hf && port2_out_en == ~s_reg.pm[3:0];
  endproperty
  a_port_fixed: assert property (p_port_fixed) else $error("port 2 control wrong");

  property p_scan_stop;
    s_oneshot_end |=> !s_reg.mode0[`ACR_RUN_BIT] && s_reg.seq == ACR_IDLE && s_reg.status[2];
  endproperty
  a_scan_stop: assert property (p_scan_stop) else $error("one-shot did not stop");

endmodule

/* testbench/acr_core_model.sv */
// Behavioural analog core facing the converter control block.
// Assumes one ref_clk domain; the bench sets the answer delay.
`timescale 1ns/10ps

module acr_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Core interface
  input wire acr_pkg::acr_core_req_t core_req,
  output acr_pkg::acr_core_rsp_t core_rsp,
  // Bench control
  input wire logic [7:0] delay
);
  import acr_pkg::*;
  logic busy;
  logic [7:0] wait_cnt;
  logic [4:0] chan_q;
  logic [9:0] noise;

  // One conversion per start; reset hold abandons it, a gated clock pauses it
  always_ff @(posedge ref_clk) begin
    noise <= rst_b ? noise + 10'h001 : 10'h000;
    if (!rst_b || core_req.reset_hold) begin
      busy <= 1'b0;
      wait_cnt <= 8'h00;
    end else if (core_req.start) begin
      busy <= 1'b1;
      wait_cnt <= delay;
      chan_q <= core_req.channel;
    end else if (busy && core_req.clock_gate && wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end else if (busy && core_req.clock_gate) begin
      busy <= 1'b0;
    end
  end

  // Data is a counter outside the valid cycle, so a stale read never looks right
  assign core_rsp.valid = busy && core_req.clock_gate && (wait_cnt == 8'h00);
  assign core_rsp.data = core_rsp.valid ? {chan_q[2:0], 7'h55} : noise;
endmodule

/* testbench/test_adc_control_registers.sv */
// Self-checking bench of the converter control block over APB.
// Assumes acr_ctrl and the behavioural core model share ref_clk.
`timescale 1ns/10ps
`include "acr_map.svh"

module test_adc_control_registers;
  import acr_pkg::*;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic hw_trigger = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, conv_end_irq_req, irq;
  logic [3:0] port2_analog_sel, port2_out_en;
  logic [1:0] conv_end_prio;
  logic [7:0] delay = 8'h0a;
  acr_core_req_t core_req;
  acr_core_rsp_t core_rsp;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int gap = 0;
  int since = 0;
  int t_start = 0;
  int t0, lat;
  int div[8] = '{64, 32, 16, 8, 6, 5, 4, 2};
  logic [11:0] ofs[8] = '{`ACR_OFS_MODE0, `ACR_OFS_ULIM, `ACR_OFS_MASK, `ACR_OFS_PRIO1,
    `ACR_OFS_PRIO0, `ACR_OFS_P2SEL, `ACR_OFS_P2DIR, `ACR_OFS_IFLAG};
  logic [7:0] rv[8] = '{8'h00, 8'hff, 8'h01, 8'h01, 8'h01, 8'hff, 8'hff, 8'h00};
  logic [4:0] chans[$];

  always #5 ref_clk = ~ref_clk;

  acr_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .core_rsp(core_rsp), .hw_trigger(hw_trigger),
    .port2_analog_sel(port2_analog_sel), .port2_out_en(port2_out_en),
    .conv_end_irq_req(conv_end_irq_req), .conv_end_prio(conv_end_prio), .irq(irq));

  acr_core_model model (.ref_clk(ref_clk), .rst_b(rst_b), .core_req(core_req),
    .core_rsp(core_rsp), .delay(delay));

  // Tick spacing and start history seen at the core interface
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    since <= since + 1;
    if (core_req.clk_tick === 1'b1) begin
      gap <= since;
      since <= 1;
    end
    if (core_req.start === 1'b1) begin
      chans.push_back(core_req.channel);
      t_start <= cyc;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  // Poll the run bit until a one-shot sequence has stopped
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `ACR_OFS_MODE0, 32'h0);
      n++;
    end while (q[7] !== 1'b0 && n < 400);
    chk("run bit idle", 32'h0, {31'h0, q[7]});
  endtask

  task automatic pulse_trigger;
    @(posedge ref_clk);
    hw_trigger <= 1'b1;
    t0 = cyc;
    repeat (2) @(posedge ref_clk);
    hw_trigger <= 1'b0;
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: the tests need well under 15000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) rd("reset value", ofs[i], {24'h0, rv[i]});
    chk("pins after reset", 32'h3f0, {conv_end_prio, port2_analog_sel, port2_out_en});
    $display("test reset done");
    // Gated converter ignores writes; unmapped address is refused
    wr(`ACR_OFS_MODE0, 8'h81);
    rd("gated mode0", `ACR_OFS_MODE0, 32'h0);
    chk("starts while gated", 32'h0, chans.size());
    chk("clock gate off", 32'h0, core_req.clock_gate);
    apb(1'b1, 12'h0f0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test gating done");
    for (int p = 0; p < 4; p++) begin
      wr(`ACR_OFS_PRIO1, {7'h0, p[1]});
      wr(`ACR_OFS_PRIO0, {7'h0, p[0]});
      @(posedge ref_clk);
      chk("priority", p, conv_end_prio);
    end
    wr(`ACR_OFS_P2SEL, 8'h05);
    wr(`ACR_OFS_P2DIR, 8'h0a);
    rd("analog select", `ACR_OFS_P2SEL, 32'hf5);
    rd("direction", `ACR_OFS_P2DIR, 32'hfa);
    chk("port pins", 32'h55, {port2_analog_sel, port2_out_en});
    $display("test priority and port done");
    wr(`ACR_OFS_CLKEN, 8'h20);
    wr(`ACR_OFS_MODE0, 8'h03);
    wr(`ACR_OFS_MODE2, 8'h01);
    @(posedge ref_clk);
    chk("comparator speed res8", 32'hb,
      {core_req.comparator_en, core_req.speed, core_req.res8});
    chk("clock gate on", 32'h1, core_req.clock_gate);
    wr(`ACR_OFS_MODE0, 8'h00);
    wr(`ACR_OFS_MODE2, 8'h00);
    @(posedge ref_clk);
    chk("comparator off", 32'h0, {core_req.comparator_en, core_req.res8});
    // Select mode one-shot conversions over every divisor
    wr(`ACR_OFS_TRIG, 8'h20);
    wr(`ACR_OFS_CHAN, 8'h02);
    wr(`ACR_OFS_MASK, 8'h00);
    wr(`ACR_OFS_ENA, 8'h02);
    delay <= 8'h8c;
    chans.delete();
    for (int f = 0; f < 8; f++) begin
      wr(`ACR_OFS_MODE0, {2'b10, f[2:0], 3'b001});
      wait_idle();
      chk("tick gap", div[f], gap);
    end
    chk("select starts", 32'h8, chans.size());
    chk("select channel", 32'h2, chans[7]);
    rd("result", `ACR_OFS_RESULT, 32'h5540);
    rd("pending flag", `ACR_OFS_IFLAG, 32'h1);
    chk("irq request", 32'h3, {conv_end_irq_req, irq});
    wr(`ACR_OFS_MASK, 8'h01);
    wr(`ACR_OFS_ENA, 8'h00);
    @(posedge ref_clk);
    chk("masked", 32'h0, {conv_end_irq_req, irq});
    wr(`ACR_OFS_IFLAG, 8'h00);
    wr(`ACR_OFS_CLR, 8'h07);
    wr(`ACR_OFS_ENA, 8'h02);
    rd("flag cleared", `ACR_OFS_IFLAG, 32'h0);
    chk("irq cleared", 32'h0, irq);
    $display("test select conversions done");
    // Inverted window: inside gives no event, lower limit above result gives one
    delay <= 8'h0a;
    wr(`ACR_OFS_MODE2, 8'h08);
    wr(`ACR_OFS_MODE0, 8'h9d);
    wait_idle();
    rd("inverted inside", `ACR_OFS_IFLAG, 32'h0);
    rd("status", `ACR_OFS_STAT, 32'h6);
    wr(`ACR_OFS_LLIM, 8'h60);
    wr(`ACR_OFS_MODE2, 8'h09);
    wr(`ACR_OFS_MODE0, 8'h9d);
    wait_idle();
    rd("inverted outside", `ACR_OFS_IFLAG, 32'h1);
    rd("8-bit result", `ACR_OFS_RESULT, 32'h5500);
    $display("test window done");
    // Scan one-shot walks four channels in order, then stops
    wr(`ACR_OFS_CHAN, 8'h00);
    chans.delete();
    wr(`ACR_OFS_MODE0, 8'hdd);
    wait_idle();
    chk("scan starts", 32'h4, chans.size());
    for (int i = 0; i < 4; i++) chk("scan channel", i, chans[i]);
    rd("scan stopped", `ACR_OFS_MODE0, 32'h5d);
    $display("test scan done");
    // Converter reset bit clears and holds the converter registers
    wr(`ACR_OFS_PRST, 8'h20);
    wr(`ACR_OFS_MODE0, 8'h81);
    chk("reset hold", 32'h1, core_req.reset_hold);
    rd("held mode0", `ACR_OFS_MODE0, 32'h0);
    rd("held lower limit", `ACR_OFS_LLIM, 32'h0);
    wr(`ACR_OFS_PRST, 8'h00);
    $display("test converter reset done");
    // Hardware trigger, no wait then with stabilisation wait
    wr(`ACR_OFS_TRIG, 8'h80);
    wr(`ACR_OFS_MODE0, 8'h9d);
    chans.delete();
    repeat (20) @(posedge ref_clk);
    chk("no start without trigger", 32'h0, chans.size());
    pulse_trigger();
    repeat (12) @(posedge ref_clk);
    lat = t_start - t0;
    chk("no-wait start", 32'h1, {31'h0, chans.size() == 1 && lat < 10});
    repeat (40) @(posedge ref_clk);
    wr(`ACR_OFS_TRIG, 8'hc0);
    pulse_trigger();
    rd("run during wait", `ACR_OFS_MODE0, 32'h9d);
    repeat (130) @(posedge ref_clk);
    lat = t_start - t0;
    chk("wait start", 32'h1, {31'h0, chans.size() == 2 && lat >= 100 && lat < 110});
    wr(`ACR_OFS_MODE0, 8'h1d);
    rd("stopped", `ACR_OFS_MODE0, 32'h1d);
    $display("test hardware trigger done");
    final_report();
  end
endmodule
